// [src/vrcs_top.sv]
// Ramp clock source select and converter clock input gating
//
// What this block does
// R1: Code 000 picks record frame clock, 001 playback, 111 record when master.
// R2: Source changes only on a control write with the apply bit set.
// R3: Force 0 waits until both frame clocks are low; force 1 switches at once.
// R4: Record clock inputs are blocked while its use bit is 0, passed when 1.
// R5: Playback clock inputs are blocked while its use bit is 0, passed when 1.
// R6: Apply bit clears itself once applied; reserved codes keep current source.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "vrcs_defs.svh"

module vrcs_top
    import vrcs_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    // Register port
    input wire vrcs_pkg::vrcs_bus_req_t bus_req,
    output logic [`VRCS_DATA_W-1:0] rd_data_reg,
    // Same-domain mode input
    input wire logic rec_master,
    // Interface clock pins
    input wire vrcs_pkg::vrcs_clk_pins_t rec_pins,
    input wire vrcs_pkg::vrcs_clk_pins_t play_pins,
    // Ramp pacing
    output logic ramp_tick_reg,
    output vrcs_pkg::vrcs_src_t ramp_src_reg,
    output logic switch_pending_reg,
    // Admitted converter clocks
    output vrcs_pkg::vrcs_clk_pins_t rec_clk_out_reg,
    output vrcs_pkg::vrcs_clk_pins_t play_clk_out_reg
);
    import vrcs_pkg::*;

    // ==========================================
    // Pin synchronisers
    // Frame and bit clocks come from the serial interfaces, so nothing reads them raw
    logic [3:0] pin_q;
    logic [3:0] pin_rise;

    vrcs_sync #(.W(4)) i_vrcs_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .din({rec_pins.frame, rec_pins.bitclk, play_pins.frame, play_pins.bitclk}),
        .q(pin_q),
        .rise(pin_rise)
    );

    logic rec_frame_s, play_frame_s;
    assign rec_frame_s = pin_q[3];
    assign play_frame_s = pin_q[1];

    // ==========================================
    // Decode of the select field: {valid, source}
    function automatic logic [1:0] sel_decode(input logic [2:0] sel, input logic mst);
        logic [1:0] res;
        res = 2'b00;
        case (sel)
            `VRCS_SEL_REC: res = {1'b1, VRCS_SRC_REC};
            `VRCS_SEL_PLAY: res = {1'b1, VRCS_SRC_PLAY};
            // Code 111 is only meaningful while the record side drives its own clocks
            `VRCS_SEL_REC_MST: res = {mst, VRCS_SRC_REC};
            default: res = 2'b00;
        endcase
        return res;
    endfunction

    function automatic logic is_wr(input vrcs_bus_req_t r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // ==========================================
    // Control registers
    logic force_reg, force_next;
    logic [2:0] sel_reg, sel_next;
    logic rec_use_reg, rec_use_next;
    logic play_use_reg, play_use_next;
    vrcs_state_t state_reg, state_next;
    vrcs_src_t target_reg, target_next;
    vrcs_src_t src_next;
    logic pending_next;
    logic [1:0] wr_dec;
    logic safe_now;
    logic ctrl_wr;

    assign safe_now = !rec_frame_s && !play_frame_s;
    assign ctrl_wr = is_wr(bus_req, `VRCS_OFS_RAMP_CTRL);
    assign wr_dec = sel_decode(bus_req.wdata[`VRCS_SEL_MSB:`VRCS_SEL_LSB], rec_master);

    always_comb begin
        force_next = force_reg;
        sel_next = sel_reg;
        rec_use_next = rec_use_reg;
        play_use_next = play_use_reg;
        state_next = state_reg;
        target_next = target_reg;
        src_next = ramp_src_reg;
        if (ce) begin
            case (state_reg)
                VRCS_ST_IDLE: begin
                    state_next = VRCS_ST_IDLE;
                end
                VRCS_ST_WAIT: begin
                    // R3 safe or forced handover
                    if (force_reg || safe_now) begin
                        src_next = target_reg;
                        // R6 apply self-clears
                        state_next = VRCS_ST_IDLE;
                    end
                end
                default: state_next = VRCS_ST_IDLE;
            endcase
            if (ctrl_wr) begin
                force_next = bus_req.wdata[`VRCS_FORCE_BIT];
                sel_next = bus_req.wdata[`VRCS_SEL_MSB:`VRCS_SEL_LSB];
                // R2 apply starts a change
                // R1 code decode
                // R6 reserved code ignored
                if (bus_req.wdata[`VRCS_APPLY_BIT] && wr_dec[1]) begin
                    target_next = vrcs_src_t'(wr_dec[0]);
                    // A new request in the completing cycle stays pending
                    state_next = VRCS_ST_WAIT;
                end
            end
            // R4 record use bit
            if (is_wr(bus_req, `VRCS_OFS_REC_GATE)) begin
                rec_use_next = bus_req.wdata[`VRCS_USE_BIT];
            end
            // R5 playback use bit
            if (is_wr(bus_req, `VRCS_OFS_PLAY_GATE)) begin
                play_use_next = bus_req.wdata[`VRCS_USE_BIT];
            end
        end
    end

    assign pending_next = (state_next == VRCS_ST_WAIT);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            force_reg <= 1'(`VRCS_RAMP_CTRL_RST >> `VRCS_FORCE_BIT);
            sel_reg <= 3'h0;
            rec_use_reg <= `VRCS_GATE_RST;
            play_use_reg <= `VRCS_GATE_RST;
            state_reg <= VRCS_ST_IDLE;
            target_reg <= VRCS_SRC_REC;
            ramp_src_reg <= VRCS_SRC_REC;
            switch_pending_reg <= 1'b0;
        end else begin
            force_reg <= force_next;
            sel_reg <= sel_next;
            rec_use_reg <= rec_use_next;
            play_use_reg <= play_use_next;
            state_reg <= state_next;
            target_reg <= target_next;
            ramp_src_reg <= src_next;
            switch_pending_reg <= pending_next;
        end
    end

    // ==========================================
    // Clock admission and ramp tick
    logic tick_next;
    vrcs_clk_pins_t rec_out_next, play_out_next;

    always_comb begin
        tick_next = ramp_tick_reg;
        rec_out_next = rec_clk_out_reg;
        play_out_next = play_clk_out_reg;
        if (ce) begin
            // Unforced switching only while both frames are low keeps this edge honest
            tick_next = (ramp_src_reg == VRCS_SRC_REC) ? pin_rise[3] : pin_rise[1];
            // R4 record gating
            rec_out_next = rec_use_reg ? vrcs_clk_pins_t'(pin_q[3:2]) : '0;
            // R5 playback gating
            play_out_next = play_use_reg ? vrcs_clk_pins_t'(pin_q[1:0]) : '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_tick_reg <= 1'b0;
            rec_clk_out_reg <= '0;
            play_clk_out_reg <= '0;
        end else begin
            ramp_tick_reg <= tick_next;
            rec_clk_out_reg <= rec_out_next;
            play_clk_out_reg <= play_out_next;
        end
    end

    // ==========================================
    // Read port
    logic [`VRCS_DATA_W-1:0] rd_next;

    always_comb begin
        rd_next = rd_data_reg;
        if (ce) begin
            rd_next = '0;
            if (bus_req.rd) begin
                case (bus_req.addr)
                    `VRCS_OFS_RAMP_CTRL: begin
                        rd_next[`VRCS_FORCE_BIT] = force_reg;
                        rd_next[`VRCS_SEL_MSB:`VRCS_SEL_LSB] = sel_reg;
                        // Apply reads back as 1 until the change has landed
                        rd_next[`VRCS_APPLY_BIT] = switch_pending_reg;
                    end
                    `VRCS_OFS_REC_GATE: rd_next[`VRCS_USE_BIT] = rec_use_reg;
                    `VRCS_OFS_PLAY_GATE: rd_next[`VRCS_USE_BIT] = play_use_reg;
                    `VRCS_OFS_STATUS: begin
                        rd_next[`VRCS_STAT_SRC_BIT] = ramp_src_reg;
                        rd_next[`VRCS_STAT_PEND_BIT] = switch_pending_reg;
                    end
                    default: rd_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_next;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge mclk iff ce);
    endclocking
    default disable iff (!arst_n);

    // Checks run only on enabled cycles, since a low enable freezes every register
    logic apply_wr;
    logic [2:0] wr_sel;
    assign apply_wr = ctrl_wr && bus_req.wdata[`VRCS_APPLY_BIT];
    assign wr_sel = bus_req.wdata[`VRCS_SEL_MSB:`VRCS_SEL_LSB];

    sel_play_forced_a: assert property ( // R1
        apply_wr && !switch_pending_reg && bus_req.wdata[`VRCS_FORCE_BIT]
        && bus_req.wdata[`VRCS_SEL_MSB:`VRCS_SEL_LSB] == `VRCS_SEL_PLAY
        ##1 !ctrl_wr |=> ramp_src_reg == VRCS_SRC_PLAY)
        else $error("forced select of playback frame clock not applied");

    no_apply_hold_a: assert property ( // R2
        ctrl_wr && !bus_req.wdata[`VRCS_APPLY_BIT] && !switch_pending_reg
        |=> ramp_src_reg == $past(ramp_src_reg) && !switch_pending_reg)
        else $error("source moved without apply");

    wait_unsafe_a: assert property ( // R3
        switch_pending_reg && !force_reg && !safe_now |=> $stable(ramp_src_reg))
        else $error("source changed while a frame clock was high");

    force_switch_a: assert property ( // R3
        switch_pending_reg && force_reg && !apply_wr
        |=> !switch_pending_reg && ramp_src_reg == $past(target_reg))
        else $error("forced switch did not land in one cycle");

    rec_ignore_a: assert property ( // R4
        !rec_use_reg [*2] |=> rec_clk_out_reg == '0)
        else $error("record clocks passed while not in use");

    rec_pass_a: assert property ( // R4
        rec_use_reg |=> rec_clk_out_reg == $past(pin_q[3:2]))
        else $error("record clocks not passed while in use");

    play_gate_a: assert property ( // R5
        play_use_reg |=> play_clk_out_reg == ($past(play_use_reg) ? $past(pin_q[1:0]) : 2'b00))
        else $error("playback clock admission wrong");

    reserved_keep_a: assert property ( // R6
        apply_wr && !switch_pending_reg && !wr_dec[1]
        |=> !switch_pending_reg && $stable(ramp_src_reg))
        else $error("reserved code disturbed the source");

    apply_start_a: assert property ( // R2
        apply_wr && wr_dec[1] |=> switch_pending_reg)
        else $error("valid apply did not start a change");

    rec_code_a: assert property ( // R1
        apply_wr && (wr_sel == `VRCS_SEL_REC || (wr_sel == `VRCS_SEL_REC_MST && rec_master))
        |=> target_reg == VRCS_SRC_REC)
        else $error("record frame clock code not decoded");

    tick_follow_a: assert property ( // R1
        ramp_src_reg == VRCS_SRC_PLAY && !pin_rise[1] |=> !ramp_tick_reg)
        else $error("ramp tick without a playback frame edge");

    safe_clear_a: assert property ( // R6
        switch_pending_reg && (force_reg || safe_now) && !apply_wr |=> !switch_pending_reg)
        else $error("apply did not clear after the change landed");

    rec_use_wr_a: assert property ( // R4
        is_wr(bus_req, `VRCS_OFS_REC_GATE) |=> rec_use_reg == $past(bus_req.wdata[`VRCS_USE_BIT]))
        else $error("record use bit not stored");

    play_ignore_a: assert property ( // R5
        !play_use_reg |=> play_clk_out_reg == '0)
        else $error("playback clocks passed while not in use");

    cover property (apply_wr ##1 switch_pending_reg [*3] ##1 !switch_pending_reg);
    cover property (switch_pending_reg && force_reg && !safe_now);
    cover property (rec_use_reg && rec_clk_out_reg.frame);
    cover property (ramp_tick_reg && ramp_src_reg == VRCS_SRC_PLAY);
    cover property (apply_wr && !wr_dec[1]);

endmodule

// [src/vrcs_defs.svh]
// Register map, field positions, reset values and source codes of the ramp clock select
`ifndef VRCS_DEFS_SVH
`define VRCS_DEFS_SVH

// ==========================================
// Bus widths
`define VRCS_ADDR_W 8
`define VRCS_DATA_W 16

// ==========================================
// Register offsets
`define VRCS_OFS_RAMP_CTRL 8'h24
`define VRCS_OFS_REC_GATE 8'h25
`define VRCS_OFS_PLAY_GATE 8'h26
`define VRCS_OFS_STATUS 8'h27

// ==========================================
// Field positions
`define VRCS_FORCE_BIT 0
`define VRCS_SEL_LSB 1
`define VRCS_SEL_MSB 3
`define VRCS_APPLY_BIT 8
`define VRCS_USE_BIT 0
`define VRCS_STAT_SRC_BIT 0
`define VRCS_STAT_PEND_BIT 1

// ==========================================
// Reset values
`define VRCS_RAMP_CTRL_RST 16'h0000
`define VRCS_GATE_RST 1'h0

// ==========================================
// Source select codes
`define VRCS_SEL_REC 3'h0
`define VRCS_SEL_PLAY 3'h1
`define VRCS_SEL_REC_MST 3'h7

`endif

// [src/vrcs_pkg.sv]
// Types shared by the ramp clock select block
`include "vrcs_defs.svh"

package vrcs_pkg;

    typedef enum logic {
        VRCS_SRC_REC = 1'b0,
        VRCS_SRC_PLAY = 1'b1
    } vrcs_src_t;

    typedef enum logic [1:0] {
        VRCS_ST_IDLE = 2'b00,
        VRCS_ST_WAIT = 2'b01
    } vrcs_state_t;

    typedef struct packed {
        logic [`VRCS_ADDR_W-1:0] addr;
        logic [`VRCS_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } vrcs_bus_req_t;

    typedef struct packed {
        logic frame;
        logic bitclk;
    } vrcs_clk_pins_t;

endpackage

// [src/vrcs_sync.sv]
// Three-stage pin synchroniser: level from stage two, rising-edge detect from stages two and three
`timescale 1ns/1ps

module vrcs_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    // Pins
    input wire logic [W-1:0] din,
    // Settled levels and edges
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);

    logic [W-1:0] s1_reg, s2_reg, s3_reg;
    logic [W-1:0] s1_next, s2_next, s3_next;

    // ==========================================
    // Stage chain
    always_comb begin
        s1_next = s1_reg;
        s2_next = s2_reg;
        s3_next = s3_reg;
        if (ce) begin
            s1_next = din;
            s2_next = s1_reg;
            s3_next = s2_reg;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Edge taken from stages two and three only; stage one may be metastable
    assign q = s2_reg;
    assign rise = s2_reg & ~s3_reg;

endmodule

// [test/vrcs_top_bench.sv]
// Self-checking bench for the ramp clock select block
`timescale 1ns/1ps
`include "vrcs_defs.svh"

module vrcs_top_bench;
    import vrcs_pkg::*;

    // ==========================================
    // Stimulus and observed signals
    logic mclk;
    logic arst_n;
    logic ce;
    vrcs_bus_req_t bus_req;
    logic [15:0] rd_data_reg;
    logic rec_master;
    vrcs_clk_pins_t rec_pins;
    vrcs_clk_pins_t play_pins;
    logic ramp_tick_reg;
    vrcs_src_t ramp_src_reg;
    logic switch_pending_reg;
    vrcs_clk_pins_t rec_clk_out_reg;
    vrcs_clk_pins_t play_clk_out_reg;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int ticks = 0;

    vrcs_top i_vrcs_top (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .bus_req(bus_req),
        .rd_data_reg(rd_data_reg),
        .rec_master(rec_master),
        .rec_pins(rec_pins),
        .play_pins(play_pins),
        .ramp_tick_reg(ramp_tick_reg),
        .ramp_src_reg(ramp_src_reg),
        .switch_pending_reg(switch_pending_reg),
        .rec_clk_out_reg(rec_clk_out_reg),
        .play_clk_out_reg(play_clk_out_reg)
    );

    // ==========================================
    // Clock, hang guard and tick counter
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (ramp_tick_reg === 1'b1) begin
            ticks <= ticks + 1;
        end
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data_reg, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic set_pins(input logic [1:0] r, input logic [1:0] p);
        @(posedge mclk);
        rec_pins <= r;
        play_pins <= p;
    endtask

    task automatic state_chk(input logic src, input logic pend);
        check({14'h0000, switch_pending_reg, ramp_src_reg}, {14'h0000, pend, src});
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        bus_req = '0;
        rec_master = 1'b0;
        rec_pins = '0;
        play_pins = '0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        rd_chk(`VRCS_OFS_RAMP_CTRL, 16'h0000);
        rd_chk(`VRCS_OFS_REC_GATE, 16'h0000);
        rd_chk(`VRCS_OFS_PLAY_GATE, 16'h0000);
        wr(8'h30, 16'hffff);
        rd_chk(8'h30, 16'h0000);
        // Select without apply keeps source
        wr(`VRCS_OFS_RAMP_CTRL, 16'h0003);
        cyc(3);
        state_chk(1'b0, 1'b0);
        rd_chk(`VRCS_OFS_RAMP_CTRL, 16'h0003);
        wr(`VRCS_OFS_RAMP_CTRL, 16'h0103);
        cyc(3);
        state_chk(1'b1, 1'b0);
        rd_chk(`VRCS_OFS_RAMP_CTRL, 16'h0003);
        // Reserved codes, and 111 without master mode, keep playback
        for (int c = 2; c < 8; c++) begin
            wr(`VRCS_OFS_RAMP_CTRL, 16'h0101 | 16'(c << 1));
            cyc(3);
            state_chk(1'b1, 1'b0);
        end
        rec_master <= 1'b1;
        wr(`VRCS_OFS_RAMP_CTRL, 16'h010f);
        cyc(3);
        state_chk(1'b0, 1'b0);
        rec_master <= 1'b0;
        // Safe handover waits for both frame clocks low
        set_pins(2'b10, 2'b10);
        cyc(4);
        wr(`VRCS_OFS_RAMP_CTRL, 16'h0102);
        cyc(6);
        state_chk(1'b0, 1'b1);
        rd_chk(`VRCS_OFS_RAMP_CTRL, 16'h0102);
        rd_chk(`VRCS_OFS_STATUS, 16'h0002);
        set_pins(2'b00, 2'b10);
        cyc(6);
        state_chk(1'b0, 1'b1);
        set_pins(2'b00, 2'b00);
        cyc(6);
        state_chk(1'b1, 1'b0);
        rd_chk(`VRCS_OFS_STATUS, 16'h0001);
        // Forced handover ignores high frame clocks
        set_pins(2'b10, 2'b10);
        cyc(4);
        wr(`VRCS_OFS_RAMP_CTRL, 16'h0101);
        cyc(3);
        state_chk(1'b0, 1'b0);
        set_pins(2'b00, 2'b00);
        cyc(6);
        // Ticks follow only the selected frame clock: record rises 4 times, playback twice
        for (int s = 0; s < 2; s++) begin
            if (s == 1) begin
                wr(`VRCS_OFS_RAMP_CTRL, 16'h0103);
                cyc(3);
            end
            ticks = 0;
            for (int i = 0; i < 4; i++) begin
                set_pins(2'b10, 2'b00);
                cyc(3);
                set_pins(2'b00, (i < 2) ? 2'b10 : 2'b00);
                cyc(3);
            end
            set_pins(2'b00, 2'b00);
            cyc(6);
            check(16'(ticks), (s == 0) ? 16'h0004 : 16'h0002);
        end
        // Converter clock inputs blocked until use bits set
        set_pins(2'b11, 2'b11);
        cyc(5);
        check({14'h0000, rec_clk_out_reg}, 16'h0000);
        check({14'h0000, play_clk_out_reg}, 16'h0000);
        wr(`VRCS_OFS_REC_GATE, 16'h0001);
        wr(`VRCS_OFS_PLAY_GATE, 16'h0001);
        cyc(5);
        check({14'h0000, rec_clk_out_reg}, 16'h0003);
        check({14'h0000, play_clk_out_reg}, 16'h0003);
        rd_chk(`VRCS_OFS_REC_GATE, 16'h0001);
        wr(`VRCS_OFS_REC_GATE, 16'h0000);
        set_pins(2'b11, 2'b01);
        cyc(5);
        check({14'h0000, rec_clk_out_reg}, 16'h0000);
        check({14'h0000, play_clk_out_reg}, 16'h0001);
        // Writes made while the enable is low are not taken
        ce <= 1'b0;
        wr(`VRCS_OFS_PLAY_GATE, 16'h0000);
        ce <= 1'b1;
        rd_chk(`VRCS_OFS_PLAY_GATE, 16'h0001);
        give_verdict();
    end

endmodule
